// *** logic/modem_link_config_regs.sv ***
// modem_link_config_regs.sv: configuration registers of the serial radio
// modem, terminator detection, receive address filter and serial framing.
// assumes: one 10 MHz clock, async active-high reset, a plain register port
// with read data one cycle after the read strobe.
//
// Behaviour
// - two-bit protocol field: transparent, reserved, packet, headerless stream
// - two-bit terminator mode: either byte, byte plus wildcard, two bytes, CR LF
// - detected terminator in terminal data ends the packet and sends it
// - two-byte terminator: first byte from first register, last from second
// - format bit picks text or binary; packet receiver output follows it
// - headerless stream receiver output ignores the sender's format bit
// - source check drops packets whose source differs from remote setting
// - destination check drops non-broadcast packets not addressed to own station number
// - diversity reception used only when its control bit is one
// - packet mode accepts broadcast when bit is zero, rejects when one
// - without diversity antenna A on zero, antenna B on one
// - extended reception aborts transmission for packet seen during sensing
// - packet mode waiting hops frequencies on zero, holds one on one
// - packet mode beacon bit one sends periodic beacons, zero sends only on command
// - character length eight bits on zero, seven bits on one
// - parity added only when enabled; odd/even ignored when disabled
// - one stop bit on zero, two stop bits on one
// - four-bit rate code; reserved codes flagged, default 9600
// - command start from header character on zero, from break on one
// - flow method XON/XOFF on zero, RTS/CTS on one; terminal must match
// - flow control towards terminal applied only when enabled
// - reception starts enabled on zero, disabled on one
`timescale 1ns/1ps
`include "modem_link_config_consts.svh"

module modem_link_config_regs
	import modem_link_config_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int ADDR_FIELD_W = 10
) (
	// clock and reset
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	// register port
	input  wire logic [ADDR_W-1:0]       i_reg_addr,
	input  wire logic [7:0]              i_reg_wdata,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	output logic      [7:0]              o_reg_rdata,
	// station addresses
	input  wire logic [ADDR_FIELD_W-1:0] i_own_station_number,
	input  wire logic [ADDR_FIELD_W-1:0] i_remote_station_setting,
	// terminal byte stream
	input  wire logic [7:0]              i_term_byte,
	input  wire logic                    i_term_valid,
	// received radio packet header
	input  wire logic                    i_rx_hdr_valid,
	input  wire logic [ADDR_FIELD_W-1:0] i_rx_hdr_src,
	input  wire logic [ADDR_FIELD_W-1:0] i_rx_hdr_dst,
	input  wire logic                    i_rx_hdr_bcast,
	input  wire logic                    i_rx_hdr_binary,
	// radio events
	input  wire logic                    i_carrier_sense,
	input  wire logic                    i_rx_packet_seen,
	input  wire logic                    i_rx_enable_cmd,
	// packet framing results
	output logic                         o_packet_send,
	output logic                         o_rx_accept,
	output logic                         o_rx_drop,
	output logic                         o_rx_binary_output,
	// decoded configuration
	output protocol_type                 o_protocol,
	output logic                         o_tx_binary,
	output logic                         o_diversity_on,
	output logic                         o_antenna_b,
	output logic                         o_tx_abort,
	output logic                         o_freq_hop,
	output logic                         o_beacon_on,
	output logic [3:0]                   o_data_bits,
	output logic                         o_parity_on,
	output logic                         o_parity_odd,
	output logic [1:0]                   o_stop_bits,
	output logic [3:0]                   o_baud_code,
	output logic                         o_baud_reserved,
	output logic                         o_cmd_by_break,
	output logic                         o_flow_on,
	output logic                         o_flow_rts_cts,
	output logic                         o_rx_enabled
);

	initial begin
		if (ADDR_W != 4 || ADDR_FIELD_W < 1)
			$error("modem_link_config_regs: unusable parameter values");
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] terminator_first_byte;
	logic [7:0] terminator_second_byte;
	logic [7:0] link_protocol_setup;
	logic [7:0] radio_receive_setup;
	logic [7:0] serial_char_framing;
	logic [7:0] serial_handshake_setup;
	logic [7:0] initial_receive_setup;
	logic       started;
	logic       rx_enabled;
	logic [7:0] next_rdata;

	wire logic [3:0] reg_sel = i_reg_addr[3:0];

	// reserved bits stay at reset value through the masks
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			terminator_first_byte  <= `RST_TERM_FIRST;
			terminator_second_byte <= `RST_TERM_SECOND;
			link_protocol_setup    <= `RST_LINK_PROTOCOL;
			radio_receive_setup    <= `RST_RADIO_RECEIVE;
			serial_char_framing    <= `RST_CHAR_FRAMING;
			serial_handshake_setup <= `RST_HANDSHAKE;
			initial_receive_setup  <= `RST_INITIAL_RECEIVE;
		end else if (i_reg_wr) begin
			if (reg_sel == `OFS_TERM_FIRST)
				terminator_first_byte <= i_reg_wdata;
			else if (reg_sel == `OFS_TERM_SECOND)
				terminator_second_byte <= i_reg_wdata;
			else if (reg_sel == `OFS_LINK_PROTOCOL)
				link_protocol_setup <= (i_reg_wdata & `MSK_LINK_PROTOCOL)
					| (`RST_LINK_PROTOCOL & ~`MSK_LINK_PROTOCOL);
			else if (reg_sel == `OFS_RADIO_RECEIVE)
				radio_receive_setup <= (i_reg_wdata & `MSK_RADIO_RECEIVE)
					| (`RST_RADIO_RECEIVE & ~`MSK_RADIO_RECEIVE);
			else if (reg_sel == `OFS_CHAR_FRAMING)
				serial_char_framing <= i_reg_wdata & `MSK_CHAR_FRAMING;
			else if (reg_sel == `OFS_HANDSHAKE)
				serial_handshake_setup <= (i_reg_wdata & `MSK_HANDSHAKE)
					| (`RST_HANDSHAKE & ~`MSK_HANDSHAKE);
			else if (reg_sel == `OFS_INITIAL_RECEIVE)
				initial_receive_setup <= (i_reg_wdata & `MSK_INITIAL_RECEIVE)
					| (`RST_INITIAL_RECEIVE & ~`MSK_INITIAL_RECEIVE);
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_sel == `OFS_TERM_FIRST)
			next_rdata = terminator_first_byte;
		else if (reg_sel == `OFS_TERM_SECOND)
			next_rdata = terminator_second_byte;
		else if (reg_sel == `OFS_LINK_PROTOCOL)
			next_rdata = link_protocol_setup;
		else if (reg_sel == `OFS_RADIO_RECEIVE)
			next_rdata = radio_receive_setup;
		else if (reg_sel == `OFS_CHAR_FRAMING)
			next_rdata = serial_char_framing;
		else if (reg_sel == `OFS_HANDSHAKE)
			next_rdata = serial_handshake_setup;
		else if (reg_sel == `OFS_INITIAL_RECEIVE)
			next_rdata = initial_receive_setup;
		else if (reg_sel == `OFS_STATUS)
			next_rdata = {7'h00, rx_enabled};
		if (i_reg_addr[ADDR_W-1:3] != '0 && reg_sel != `OFS_STATUS)
			next_rdata = 8'h00;
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= next_rdata;
		else
			o_reg_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// decoded configuration

	term_mode_type term_mode;
	assign term_mode = term_mode_type'(
		link_protocol_setup[`FLD_TERM_HI:`FLD_TERM_LO]);
	assign o_protocol = protocol_type'(
		link_protocol_setup[`FLD_PROTO_HI:`FLD_PROTO_LO]);
	assign o_tx_binary = link_protocol_setup[`FLD_FORMAT];

	wire logic packet_mode = (o_protocol == proto_packet);

	assign o_diversity_on = radio_receive_setup[`FLD_DIVERSITY];
	// antenna choice only meaningful without diversity
	assign o_antenna_b = ~o_diversity_on
		& radio_receive_setup[`FLD_ANTENNA_B];
	assign o_tx_abort = radio_receive_setup[`FLD_EXT_RECEIVE]
		& i_carrier_sense & i_rx_packet_seen;
	assign o_freq_hop = packet_mode
		& ~radio_receive_setup[`FLD_FREQ_HOLD];
	assign o_beacon_on = packet_mode
		& radio_receive_setup[`FLD_BEACON];

	assign o_data_bits = serial_char_framing[`FLD_DATA7]
		? 4'h7 : 4'h8;
	assign o_parity_on = serial_char_framing[`FLD_PARITY_EN];
	assign o_parity_odd = o_parity_on
		& serial_char_framing[`FLD_PARITY_ODD];
	assign o_stop_bits = serial_char_framing[`FLD_STOP2]
		? 2'h2 : 2'h1;
	assign o_baud_code = serial_char_framing[`FLD_BAUD_HI:`FLD_BAUD_LO];
	// codes 8..11 and 15 are reserved
	assign o_baud_reserved = (o_baud_code[3] & ~o_baud_code[2])
		| (o_baud_code == 4'hF);
	assign o_cmd_by_break = serial_handshake_setup[`FLD_BREAK_HDR];
	assign o_flow_on = serial_handshake_setup[`FLD_FLOW_EN];
	// method only reported while flow control is on
	assign o_flow_rts_cts = o_flow_on
		& serial_handshake_setup[`FLD_HW_FLOW];

	////////////////////////////////////////////////////////////////////////
	// reception enable state

	// follows the start-up setting until the enable command is seen
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			started    <= 1'b0;
			rx_enabled <= 1'b0;
		end else if (i_rx_enable_cmd) begin
			started    <= 1'b1;
			rx_enabled <= 1'b1;
		end else if (!started) begin
			rx_enabled <= ~initial_receive_setup[`FLD_RX_OFF_INIT];
		end
	end
	assign o_rx_enabled = rx_enabled;

	////////////////////////////////////////////////////////////////////////
	// terminator detection on terminal data

	term_scan_type scan;
	logic          hit_first;
	logic          hit_second;
	logic          two_step;
	logic [7:0]    lead_byte;
	logic [7:0]    tail_byte;

	always_comb begin
		two_step  = 1'b1;
		lead_byte = terminator_first_byte;
		tail_byte = terminator_second_byte;
		if (term_mode == term_cr_lf) begin
			lead_byte = `CHAR_CR;
			tail_byte = `CHAR_LF;
		end else if (term_mode == term_either_byte) begin
			two_step = 1'b0;
		end
		hit_first  = (i_term_byte == lead_byte);
		hit_second = (i_term_byte == tail_byte);
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			scan          <= scan_idle;
			o_packet_send <= 1'b0;
		end else begin
			o_packet_send <= 1'b0;
			// a link protocol write drops a half-seen terminator
			if (i_reg_wr && reg_sel == `OFS_LINK_PROTOCOL)
				scan <= scan_idle;
			else if (i_term_valid) begin
				case (scan)
					scan_idle: begin
						if (!two_step && (hit_first || hit_second))
							o_packet_send <= 1'b1;
						else if (two_step && hit_first)
							scan <= scan_have_first;
					end
					scan_have_first: begin
						if (term_mode == term_byte_wild || hit_second) begin
							o_packet_send <= 1'b1;
							scan          <= scan_idle;
						end else if (!hit_first) begin
							scan <= scan_idle;
						end
					end
					default: scan <= scan_idle;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive address filter

	logic drop_now;
	always_comb begin
		drop_now = ~rx_enabled;
		if (link_protocol_setup[`FLD_SRC_CHECK]
			&& i_rx_hdr_src != i_remote_station_setting)
			drop_now = 1'b1;
		if (link_protocol_setup[`FLD_DST_CHECK] && !i_rx_hdr_bcast
			&& i_rx_hdr_dst != i_own_station_number)
			drop_now = 1'b1;
		if (packet_mode && i_rx_hdr_bcast
			&& radio_receive_setup[`FLD_BCAST_REJECT])
			drop_now = 1'b1;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_accept        <= 1'b0;
			o_rx_drop          <= 1'b0;
			o_rx_binary_output <= 1'b0;
		end else begin
			o_rx_accept <= i_rx_hdr_valid & ~drop_now;
			o_rx_drop   <= i_rx_hdr_valid & drop_now;
			if (i_rx_hdr_valid)
				// stream receiver ignores the sender's format
				o_rx_binary_output <= packet_mode
					& i_rx_hdr_binary;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	read_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	proto_field_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst) o_protocol == protocol_type'(
		link_protocol_setup[`FLD_PROTO_HI:`FLD_PROTO_LO]))
		else $error("protocol decode wrong");
	reserved_keep_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		link_protocol_setup[5] == 1'b0 && radio_receive_setup[7] == 1'b0)
		else $error("reserved bit changed");
	crlf_send_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_term_valid && i_term_byte == `CHAR_CR && scan == scan_idle
		&& term_mode == term_cr_lf && !i_reg_wr) ##1 (i_term_valid
		&& i_term_byte == `CHAR_LF && term_mode == term_cr_lf
		&& !i_reg_wr) |=> o_packet_send)
		else $error("cr lf did not end packet");
	src_drop_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_rx_hdr_valid && link_protocol_setup[`FLD_SRC_CHECK]
		&& i_rx_hdr_src != i_remote_station_setting)
		|=> o_rx_drop && !o_rx_accept)
		else $error("source mismatch accepted");
	dst_drop_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_rx_hdr_valid && link_protocol_setup[`FLD_DST_CHECK]
		&& !i_rx_hdr_bcast && i_rx_hdr_dst != i_own_station_number)
		|=> o_rx_drop)
		else $error("destination mismatch accepted");
	bcast_drop_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_rx_hdr_valid && i_rx_hdr_bcast && o_protocol == proto_packet
		&& radio_receive_setup[`FLD_BCAST_REJECT]) |=> o_rx_drop)
		else $error("broadcast accepted while rejected");
	antenna_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		o_diversity_on |-> !o_antenna_b)
		else $error("antenna forced under diversity");
	parity_odd_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		!o_parity_on |-> !o_parity_odd)
		else $error("odd parity without parity");
	rx_enable_a: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_rx_enable_cmd |=> rx_enabled && started)
		else $error("enable command ignored");

	send_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_packet_send);
	drop_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_drop);
	accept_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_accept && o_rx_binary_output);
	abort_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_tx_abort);

endmodule : modem_link_config_regs

// *** logic/modem_link_config_consts.svh ***
// modem_link_config_consts.svh: offsets, fields and reset values of the
// modem link configuration registers.
// assumes: included by the register bank module and the bench only.
`ifndef MODEM_LINK_CONFIG_CONSTS_SVH
`define MODEM_LINK_CONFIG_CONSTS_SVH

// register offsets on the plain register port
`define OFS_TERM_FIRST      4'h0
`define OFS_TERM_SECOND     4'h1
`define OFS_LINK_PROTOCOL   4'h2
`define OFS_RADIO_RECEIVE   4'h3
`define OFS_CHAR_FRAMING    4'h4
`define OFS_HANDSHAKE       4'h5
`define OFS_INITIAL_RECEIVE 4'h6
`define OFS_STATUS          4'h7

// reset values
`define RST_TERM_FIRST      8'h0D
`define RST_TERM_SECOND     8'h0A
`define RST_LINK_PROTOCOL   8'h8C
`define RST_RADIO_RECEIVE   8'h00
`define RST_CHAR_FRAMING    8'h05
`define RST_HANDSHAKE       8'h09
`define RST_INITIAL_RECEIVE 8'h00

// writable bit masks; reserved bits keep their reset value
`define MSK_LINK_PROTOCOL   8'hDF
`define MSK_RADIO_RECEIVE   8'h7E
`define MSK_CHAR_FRAMING    8'hFF
`define MSK_HANDSHAKE       8'h13
`define MSK_INITIAL_RECEIVE 8'h80

// field positions
`define FLD_PROTO_HI        7
`define FLD_PROTO_LO        6
`define FLD_FORMAT          4
`define FLD_TERM_HI         3
`define FLD_TERM_LO         2
`define FLD_SRC_CHECK       1
`define FLD_DST_CHECK       0
`define FLD_DIVERSITY       6
`define FLD_BCAST_REJECT    5
`define FLD_ANTENNA_B       4
`define FLD_EXT_RECEIVE     3
`define FLD_FREQ_HOLD       2
`define FLD_BEACON          1
`define FLD_DATA7           7
`define FLD_PARITY_EN       6
`define FLD_PARITY_ODD      5
`define FLD_STOP2           4
`define FLD_BAUD_HI         3
`define FLD_BAUD_LO         0
`define FLD_BREAK_HDR       4
`define FLD_HW_FLOW         1
`define FLD_FLOW_EN         0
`define FLD_RX_OFF_INIT     7

// fixed characters
`define CHAR_CR             8'h0D
`define CHAR_LF             8'h0A

`endif

// *** logic/modem_link_config_pkg.sv ***
// modem_link_config_pkg.sv: types shared by the configuration register bank.
// assumes: compiled before the register bank module.
package modem_link_config_pkg;

	typedef enum logic [1:0] {
		proto_transparent,
		proto_reserved,
		proto_packet,
		proto_headerless
	} protocol_type;

	typedef enum logic [1:0] {
		term_either_byte,
		term_byte_wild,
		term_two_byte,
		term_cr_lf
	} term_mode_type;

	typedef enum logic [1:0] {
		scan_idle,
		scan_have_first
	} term_scan_type;

endpackage : modem_link_config_pkg

// *** bench/modem_terminal_model.sv ***
// modem_terminal_model.sv: terminal equipment feeding the modem's byte stream
// and issuing the reception-enable command.
// assumes: driven by hierarchical task calls from the bench, one clock.
`timescale 1ns/1ps

module modem_terminal_model (
	// clock
	input  wire logic i_sys_clk,
	// terminal side of the register bank
	output logic [7:0] o_term_byte,
	output logic       o_term_valid,
	output logic       o_rx_enable_cmd
);
	logic [7:0] last_byte;

	initial begin
		o_term_byte     = 8'h00;
		o_term_valid    = 1'b0;
		o_rx_enable_cmd = 1'b0;
		last_byte       = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// bytes go back to back; between frames the data lines show the
	// inverse of the last byte, so stale data never passes for a byte
	task automatic send_bytes(input logic [7:0] q[$]);
		foreach (q[k]) begin
			@(posedge i_sys_clk);
			o_term_valid <= 1'b1;
			o_term_byte  <= q[k];
			last_byte = q[k];
		end
		@(posedge i_sys_clk);
		o_term_valid <= 1'b0;
		o_term_byte  <= ~last_byte;
		#1;
	endtask : send_bytes

	// sent in the last test, after reception was set to start disabled
	task automatic send_enable();
		@(posedge i_sys_clk);
		o_rx_enable_cmd <= 1'b1;
		@(posedge i_sys_clk);
		o_rx_enable_cmd <= 1'b0;
		#1;
	endtask : send_enable
endmodule : modem_terminal_model

// *** bench/tb_modem_link_config_regs.sv ***
// tb_modem_link_config_regs.sv: self-checking bench of the config registers.
// assumes: terminal model in its own file, design constants from the header.
`timescale 1ns/1ps
`include "modem_link_config_consts.svh"
`define CHECK_EQ(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
		end \
	end

module tb_modem_link_config_regs
	import modem_link_config_pkg::*;
	;
	logic         sys_clk, rst, reg_wr, reg_rd, hdr_valid, hdr_bcast, hdr_bin;
	logic         carrier, seen, term_valid, enable_cmd, packet_send;
	logic [3:0]   reg_addr, data_bits, baud_code;
	logic [7:0]   reg_wdata, reg_rdata, term_byte;
	logic [9:0]   own, remote, hdr_src, hdr_dst;
	logic         rx_accept, rx_drop, rx_bin_out, tx_binary, diversity;
	logic         antenna_b, tx_abort, freq_hop, beacon, parity_on, parity_odd;
	logic         baud_res, cmd_break, flow_on, rts_cts, rx_enabled;
	logic [1:0]   stop_bits;
	protocol_type protocol;
	int           mismatches, cmp_count;
	logic [7:0]   rst_tab [0:6] = '{`RST_TERM_FIRST, `RST_TERM_SECOND,
		`RST_LINK_PROTOCOL, `RST_RADIO_RECEIVE, `RST_CHAR_FRAMING,
		`RST_HANDSHAKE, `RST_INITIAL_RECEIVE};
	logic [7:0]   msk_tab [0:6] = '{8'hFF, 8'hFF, `MSK_LINK_PROTOCOL,
		`MSK_RADIO_RECEIVE, `MSK_CHAR_FRAMING, `MSK_HANDSHAKE,
		`MSK_INITIAL_RECEIVE};

	modem_link_config_regs i_modem_link_config_regs (
		.i_sys_clk(sys_clk), .i_rst(rst), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.o_reg_rdata(reg_rdata), .i_own_station_number(own),
		.i_remote_station_setting(remote), .i_term_byte(term_byte),
		.i_term_valid(term_valid), .i_rx_hdr_valid(hdr_valid),
		.i_rx_hdr_src(hdr_src), .i_rx_hdr_dst(hdr_dst),
		.i_rx_hdr_bcast(hdr_bcast), .i_rx_hdr_binary(hdr_bin),
		.i_carrier_sense(carrier), .i_rx_packet_seen(seen),
		.i_rx_enable_cmd(enable_cmd), .o_packet_send(packet_send),
		.o_rx_accept(rx_accept), .o_rx_drop(rx_drop),
		.o_rx_binary_output(rx_bin_out), .o_protocol(protocol),
		.o_tx_binary(tx_binary), .o_diversity_on(diversity),
		.o_antenna_b(antenna_b), .o_tx_abort(tx_abort),
		.o_freq_hop(freq_hop), .o_beacon_on(beacon),
		.o_data_bits(data_bits), .o_parity_on(parity_on),
		.o_parity_odd(parity_odd), .o_stop_bits(stop_bits),
		.o_baud_code(baud_code), .o_baud_reserved(baud_res),
		.o_cmd_by_break(cmd_break), .o_flow_on(flow_on),
		.o_flow_rts_cts(rts_cts), .o_rx_enabled(rx_enabled));

	modem_terminal_model i_modem_terminal_model (
		.i_sys_clk(sys_clk), .o_term_byte(term_byte),
		.o_term_valid(term_valid), .o_rx_enable_cmd(enable_cmd));

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : reg_write

	task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHECK_EQ("reg_rdata", exp, reg_rdata)
	endtask : reg_check

	task automatic hdr(input logic [9:0] s, d, input logic b, bn, acc);
		@(posedge sys_clk);
		hdr_valid <= 1'b1;
		hdr_src   <= s;
		hdr_dst   <= d;
		hdr_bcast <= b;
		hdr_bin   <= bn;
		@(posedge sys_clk);
		hdr_valid <= 1'b0;
		#1;
		`CHECK_EQ("rx_accept", acc, rx_accept)
		`CHECK_EQ("rx_drop", ~acc, rx_drop)
	endtask : hdr

	// one pulse, one cycle after the completing byte, then low again
	task automatic term_case(input logic [1:0] m, input logic [7:0] q[$],
		input logic exp);
		reg_write(`OFS_LINK_PROTOCOL, {4'h8, m, 2'b00});
		i_modem_terminal_model.send_bytes(q);
		`CHECK_EQ("packet_send", exp, packet_send)
		@(posedge sys_clk);
		#1;
		`CHECK_EQ("packet_send_end", 1'b0, packet_send)
	endtask : term_case

	////////////////////////////////////////////////////////////////////////
	task automatic test_defaults();
		for (int i = 0; i < 7; i++)
			reg_check(4'(i), rst_tab[i]);
		reg_check(`OFS_STATUS, 8'h01);
		`CHECK_EQ("protocol", proto_packet, protocol)
		`CHECK_EQ("tx_binary", 1'b0, tx_binary)
		`CHECK_EQ("data_bits", 4'd8, data_bits)
		`CHECK_EQ("stop_bits", 2'd1, stop_bits)
		`CHECK_EQ("baud_code", 4'h5, baud_code)
		`CHECK_EQ("flow_on", 1'b1, flow_on)
		`CHECK_EQ("rx_enabled", 1'b1, rx_enabled)
		$display("test_defaults done");
	endtask : test_defaults

	task automatic test_masks();
		for (int i = 0; i < 7; i++) begin
			reg_write(4'(i), 8'hFF);
			reg_check(4'(i), rst_tab[i] | msk_tab[i]);
			reg_write(4'(i), 8'h00);
			reg_check(4'(i), rst_tab[i] & ~msk_tab[i]);
			reg_write(4'(i), rst_tab[i]);
		end
		reg_write(4'h8, 8'hFF);
		reg_check(4'h8, 8'h00);
		reg_write(`OFS_STATUS, 8'h00);
		reg_check(`OFS_STATUS, 8'h01);
		$display("test_masks done");
	endtask : test_masks

	task automatic test_protocol();
		for (int p = 0; p < 4; p++) begin
			reg_write(`OFS_LINK_PROTOCOL, {2'(p), 6'h1C});
			`CHECK_EQ("protocol", protocol_type'(p), protocol)
			`CHECK_EQ("tx_binary", 1'b1, tx_binary)
		end
		reg_write(`OFS_LINK_PROTOCOL, `RST_LINK_PROTOCOL);
		$display("test_protocol done");
	endtask : test_protocol

	task automatic test_terminator();
		reg_write(`OFS_TERM_FIRST, 8'h21);
		reg_write(`OFS_TERM_SECOND, 8'h22);
		term_case(2'd0, {8'h55, 8'h22}, 1'b1);
		term_case(2'd0, {8'h21}, 1'b1);
		term_case(2'd0, {8'h55}, 1'b0);
		term_case(2'd1, {8'h21, 8'h55}, 1'b1);
		term_case(2'd2, {8'h21, 8'h21, 8'h22}, 1'b1);
		term_case(2'd2, {8'h21, 8'h55, 8'h22}, 1'b0);
		term_case(2'd2, {8'h22, 8'h21}, 1'b0);
		term_case(2'd1, {8'h55}, 1'b0);
		term_case(2'd3, {8'h0D, 8'h0A}, 1'b1);
		term_case(2'd3, {8'h21, 8'h22}, 1'b0);
		reg_write(`OFS_LINK_PROTOCOL, `RST_LINK_PROTOCOL);
		reg_write(`OFS_TERM_FIRST, `RST_TERM_FIRST);
		reg_write(`OFS_TERM_SECOND, `RST_TERM_SECOND);
		$display("test_terminator done");
	endtask : test_terminator

	task automatic test_rx_filter();
		reg_write(`OFS_LINK_PROTOCOL, 8'h8F);
		hdr(remote, own, 1'b0, 1'b0, 1'b1);
		hdr(10'd3, own, 1'b0, 1'b0, 1'b0);
		hdr(remote, 10'd4, 1'b0, 1'b0, 1'b0);
		hdr(remote, 10'd4, 1'b1, 1'b0, 1'b1);
		reg_write(`OFS_RADIO_RECEIVE, 8'h20);
		hdr(remote, 10'd4, 1'b1, 1'b0, 1'b0);
		hdr(remote, own, 1'b0, 1'b1, 1'b1);
		`CHECK_EQ("rx_bin_out", 1'b1, rx_bin_out)
		reg_write(`OFS_LINK_PROTOCOL, 8'hCC);
		hdr(10'd3, 10'd4, 1'b1, 1'b1, 1'b1);
		`CHECK_EQ("rx_bin_out", 1'b0, rx_bin_out)
		reg_write(`OFS_LINK_PROTOCOL, `RST_LINK_PROTOCOL);
		reg_write(`OFS_RADIO_RECEIVE, `RST_RADIO_RECEIVE);
		$display("test_rx_filter done");
	endtask : test_rx_filter

	task automatic test_radio();
		reg_write(`OFS_RADIO_RECEIVE, 8'h16);
		`CHECK_EQ("diversity", 1'b0, diversity)
		`CHECK_EQ("antenna_b", 1'b1, antenna_b)
		`CHECK_EQ("freq_hop", 1'b0, freq_hop)
		`CHECK_EQ("beacon", 1'b1, beacon)
		@(posedge sys_clk);
		carrier <= 1'b1;
		seen    <= 1'b1;
		reg_write(`OFS_RADIO_RECEIVE, 8'h48);
		`CHECK_EQ("diversity", 1'b1, diversity)
		`CHECK_EQ("freq_hop", 1'b1, freq_hop)
		`CHECK_EQ("beacon", 1'b0, beacon)
		`CHECK_EQ("tx_abort", 1'b1, tx_abort)
		reg_write(`OFS_RADIO_RECEIVE, 8'h00);
		`CHECK_EQ("tx_abort", 1'b0, tx_abort)
		reg_write(`OFS_RADIO_RECEIVE, 8'h50);
		`CHECK_EQ("antenna_b", 1'b0, antenna_b)
		@(posedge sys_clk);
		carrier <= 1'b0;
		seen    <= 1'b0;
		$display("test_radio done");
	endtask : test_radio

	task automatic test_framing();
		reg_write(`OFS_CHAR_FRAMING, 8'hF0);
		`CHECK_EQ("data_bits", 4'd7, data_bits)
		`CHECK_EQ("parity_on", 1'b1, parity_on)
		`CHECK_EQ("parity_odd", 1'b1, parity_odd)
		`CHECK_EQ("stop_bits", 2'd2, stop_bits)
		reg_write(`OFS_CHAR_FRAMING, 8'h20);
		`CHECK_EQ("parity_on", 1'b0, parity_on)
		`CHECK_EQ("parity_odd", 1'b0, parity_odd)
		for (int c = 0; c < 16; c++) begin
			reg_write(`OFS_CHAR_FRAMING, {4'h0, 4'(c)});
			`CHECK_EQ("baud_code", 4'(c), baud_code)
			`CHECK_EQ("baud_res", (c >= 8 && c <= 11) || c == 15,
				baud_res)
		end
		reg_write(`OFS_CHAR_FRAMING, `RST_CHAR_FRAMING);
		$display("test_framing done");
	endtask : test_framing

	task automatic test_handshake();
		reg_write(`OFS_HANDSHAKE, 8'h13);
		`CHECK_EQ("cmd_break", 1'b1, cmd_break)
		`CHECK_EQ("rts_cts", 1'b1, rts_cts)
		reg_write(`OFS_HANDSHAKE, 8'h02);
		`CHECK_EQ("cmd_break", 1'b0, cmd_break)
		`CHECK_EQ("flow_on", 1'b0, flow_on)
		`CHECK_EQ("rts_cts", 1'b0, rts_cts)
		reg_write(`OFS_HANDSHAKE, `RST_HANDSHAKE);
		$display("test_handshake done");
	endtask : test_handshake

	// reception stays off until the enable command
	task automatic test_initial_rx();
		reg_write(`OFS_INITIAL_RECEIVE, 8'h80);
		@(posedge sys_clk);
		#1;
		`CHECK_EQ("rx_enabled", 1'b0, rx_enabled)
		hdr(remote, own, 1'b0, 1'b0, 1'b0);
		i_modem_terminal_model.send_enable();
		`CHECK_EQ("rx_enabled", 1'b1, rx_enabled)
		hdr(remote, own, 1'b0, 1'b0, 1'b1);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		reg_check(`OFS_INITIAL_RECEIVE, `RST_INITIAL_RECEIVE);
		reg_check(`OFS_STATUS, 8'h01);
		$display("test_initial_rx done");
	endtask : test_initial_rx

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		{rst, reg_wr, reg_rd, hdr_valid, hdr_bcast, hdr_bin} = 6'b10_0000;
		{carrier, seen} = 2'b00;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		own       = 10'd5;
		remote    = 10'd9;
		hdr_src   = 10'd0;
		hdr_dst   = 10'd0;
		mismatches = 0;
		cmp_count  = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		test_defaults();
		test_masks();
		test_protocol();
		test_terminator();
		test_rx_filter();
		test_radio();
		test_framing();
		test_handshake();
		test_initial_rx();
		wrap_up();
	end
endmodule : tb_modem_link_config_regs
